// File: shared/pcfg_map.vh
// register offsets, field positions and reset values of the synthesizer configuration bank
`ifndef PCFG_MAP_VH
`define PCFG_MAP_VH
`define PCFG_OFS_OUTDIV_LO 7'h17
`define PCFG_OFS_REFDIV 7'h18
`define PCFG_OFS_NINT_HI 7'h19
`define PCFG_OFS_NINT_LO 7'h1A
`define PCFG_OFS_NUM2 7'h1B
`define PCFG_OFS_NUM1 7'h1C
`define PCFG_OFS_NUM0 7'h1D
`define PCFG_OFS_DEN2 7'h1E
`define PCFG_OFS_DEN1 7'h1F
`define PCFG_OFS_DEN0 7'h20
`define PCFG_OFS_MOD 7'h21
`define PCFG_OFS_LOOP 7'h22
`define PCFG_RST_OUTDIV_LO 8'h4E
`define PCFG_RST_REFDIV 8'h01
`define PCFG_RST_NINT_HI 8'h00
`define PCFG_RST_NINT_LO 8'hDC
`define PCFG_RST_NUM2 8'h1C
`define PCFG_RST_NUM1 8'hB3
`define PCFG_RST_NUM0 8'hE3
`define PCFG_RST_DEN2 8'h3F
`define PCFG_RST_DEN1 8'hFF
`define PCFG_RST_DEN0 8'hFF
`define PCFG_RST_MOD 8'h03
`define PCFG_RST_LOOP 8'h24
`define PCFG_MSK_REFDIV 8'h01
`define PCFG_MSK_NINT_HI 8'h0F
`define PCFG_MSK_FULL 8'hFF
`define PCFG_MSK_TOP6 8'h3F
`define PCFG_MSK_MOD 8'h0F
`define PCFG_MSK_LOOP 8'h2F
`define PCFG_BIT_DOUBLER 5
`define PCFG_DITHER_HI 3
`define PCFG_DITHER_LO 2
`define PCFG_ORDER_HI 1
`define PCFG_ORDER_LO 0
`define PCFG_CP_HI 3
`define PCFG_CP_LO 0
`define PCFG_CP_1P6MA 4'h4
`define PCFG_CP_6P4MA 4'h8
`define PCFG_DITHER_WEAK 2'h0
`define PCFG_DITHER_OFF 2'h3
`define PCFG_ORDER_INT 2'h0
`define PCFG_ORDER_THIRD 2'h3
`define PCFG_BIT_REFDIV 0
`define PCFG_NINT_HI_MSB 3
`define PCFG_FRAC_TOP_MSB 5
`define PCFG_FIELD_LSB 0
`define PCFG_RDATA_ZERO 8'h00
`define PCFG_NREGS 12
`endif

// File: logic/pcfg_byte_reg.v
// one masked configuration byte with reset value
`default_nettype none
module pcfg_byte_reg #(
  parameter [7:0] RST_VAL = 8'h00,
  parameter [7:0] MASK = 8'hFF
) (
  input wire clk, // system clock
  input wire rst_n, // synchronous reset, active low
  input wire wr_en, // write strobe for this byte
  input wire [7:0] wr_data, // byte written
  output reg [7:0] q // stored value, reserved bits zero
);
  // reserved bits never store, so they read zero
  always @(posedge clk)
  begin
    if (!rst_n)
      q <= RST_VAL & MASK;
    else if (wr_en)
      q <= wr_data & MASK;
  end
endmodule // pcfg_byte_reg
`default_nettype wire

// File: logic/pcfg_regs.v
// configuration register bank of the fractional-n synthesizer
`include "pcfg_map.vh"
// What this block does
// - the 9-bit output divider takes its low eight bits from a byte register resetting to 0x4E.
// - the reference divide select bit divides by four when one, bypasses when zero, and resets to one.
// - the 12-bit feedback integer takes bits 11:8 from one register (reset 0x0) and 7:0 from the next (0xDC).
// - the 22-bit numerator joins three bytes for bits 21:16, 15:8, 7:0, resetting to 0x1C, 0xB3, 0xE3.
// - the 22-bit denominator joins three bytes for bits 21:16, 15:8, 7:0, resetting to 0x3F, 0xFF, 0xFF.
// - order field bits 1:0 selects integer at 0 and third order at 3, reserves 1 and 2, and resets to 3.
// - bit 5 of loop control enables the reference doubler and resets to one.
// - the 4-bit charge pump code gives 1.6 mA at 4 and 6.4 mA at 8, resets to 4, other codes unsupported.
`default_nettype none
module pcfg_regs (
  input wire clk, // system clock, 50 MHz
  input wire rst_n, // synchronous reset, active low
  input wire reg_wr, // write strobe from serial control
  input wire [6:0] reg_addr, // register offset
  input wire [7:0] reg_wdata, // write data
  output reg [7:0] reg_rdata, // registered read data
  output wire reg_hit, // offset lies in this bank
  output wire [7:0] out_div_low, // output divider bits 7:0
  output wire ref_divide_select, // 1: divide reference by four
  output wire [11:0] feedback_integer_value, // integer n divider
  output wire [21:0] frac_numerator_value, // fractional numerator
  output wire [21:0] frac_denominator_value, // fractional denominator
  output wire [1:0] dither_select, // modulator dither mode
  output wire [1:0] modulator_order, // modulator order
  output wire doubler_enable, // reference doubler on
  output wire [3:0] charge_pump_current_code, // charge pump current
  output wire frac_mode, // third order fractional active
  output wire dither_active, // dither in use
  output wire config_reserved_code // a reserved or unsupported code is held
);
  // ====================================================
  // address decode
  function [11:0] pcfg_dec;
    input [6:0] a;
    begin
      pcfg_dec = 12'h000;
      case (a)
        `PCFG_OFS_OUTDIV_LO: pcfg_dec = 12'h001;
        `PCFG_OFS_REFDIV: pcfg_dec = 12'h002;
        `PCFG_OFS_NINT_HI: pcfg_dec = 12'h004;
        `PCFG_OFS_NINT_LO: pcfg_dec = 12'h008;
        `PCFG_OFS_NUM2: pcfg_dec = 12'h010;
        `PCFG_OFS_NUM1: pcfg_dec = 12'h020;
        `PCFG_OFS_NUM0: pcfg_dec = 12'h040;
        `PCFG_OFS_DEN2: pcfg_dec = 12'h080;
        `PCFG_OFS_DEN1: pcfg_dec = 12'h100;
        `PCFG_OFS_DEN0: pcfg_dec = 12'h200;
        `PCFG_OFS_MOD: pcfg_dec = 12'h400;
        `PCFG_OFS_LOOP: pcfg_dec = 12'h800;
        default: pcfg_dec = 12'h000;
      endcase
    end
  endfunction

  // third order fractional operation selected
  function pcfg_frac;
    input [7:0] m;
    begin
      pcfg_frac = (m[`PCFG_ORDER_HI:`PCFG_ORDER_LO] == `PCFG_ORDER_THIRD);
    end
  endfunction

  // weak dither in use while fractional
  function pcfg_dith;
    input [7:0] m;
    begin
      pcfg_dith = pcfg_frac(m) & (m[`PCFG_DITHER_HI:`PCFG_DITHER_LO] == `PCFG_DITHER_WEAK);
    end
  endfunction

  // any reserved dither or order code, or an unsupported pump code
  function pcfg_resv;
    input [7:0] m;
    input [7:0] l;
    reg [1:0] dth;
    reg [1:0] ord;
    reg [3:0] cp;
    begin
      dth = m[`PCFG_DITHER_HI:`PCFG_DITHER_LO];
      ord = m[`PCFG_ORDER_HI:`PCFG_ORDER_LO];
      cp = l[`PCFG_CP_HI:`PCFG_CP_LO];
      pcfg_resv = ((dth != `PCFG_DITHER_WEAK) & (dth != `PCFG_DITHER_OFF))
        | ((ord != `PCFG_ORDER_INT) & (ord != `PCFG_ORDER_THIRD))
        | ((cp != `PCFG_CP_1P6MA) & (cp != `PCFG_CP_6P4MA));
    end
  endfunction

  wire [11:0] sel;
  wire [11:0] wr_sel;
  wire [7:0] r_outdiv, r_ref, r_nhi, r_nlo, r_n2, r_n1, r_n0, r_d2, r_d1, r_d0, r_mod, r_loop;
  assign sel = pcfg_dec(reg_addr);
  assign wr_sel = {`PCFG_NREGS{reg_wr}} & sel;
  assign reg_hit = |sel;

  // ====================================================
  // storage bytes
  pcfg_byte_reg #(.RST_VAL(`PCFG_RST_OUTDIV_LO), .MASK(`PCFG_MSK_FULL)) u_outdiv (
    .clk(clk),
    .rst_n(rst_n),
    .wr_en(wr_sel[0]),
    .wr_data(reg_wdata),
    .q(r_outdiv)
  );
  pcfg_byte_reg #(.RST_VAL(`PCFG_RST_REFDIV), .MASK(`PCFG_MSK_REFDIV)) u_ref (
    .clk(clk),
    .rst_n(rst_n),
    .wr_en(wr_sel[1]),
    .wr_data(reg_wdata),
    .q(r_ref)
  );
  pcfg_byte_reg #(.RST_VAL(`PCFG_RST_NINT_HI), .MASK(`PCFG_MSK_NINT_HI)) u_nhi (
    .clk(clk),
    .rst_n(rst_n),
    .wr_en(wr_sel[2]),
    .wr_data(reg_wdata),
    .q(r_nhi)
  );
  pcfg_byte_reg #(.RST_VAL(`PCFG_RST_NINT_LO), .MASK(`PCFG_MSK_FULL)) u_nlo (
    .clk(clk),
    .rst_n(rst_n),
    .wr_en(wr_sel[3]),
    .wr_data(reg_wdata),
    .q(r_nlo)
  );
  pcfg_byte_reg #(.RST_VAL(`PCFG_RST_NUM2), .MASK(`PCFG_MSK_TOP6)) u_n2 (
    .clk(clk),
    .rst_n(rst_n),
    .wr_en(wr_sel[4]),
    .wr_data(reg_wdata),
    .q(r_n2)
  );
  pcfg_byte_reg #(.RST_VAL(`PCFG_RST_NUM1), .MASK(`PCFG_MSK_FULL)) u_n1 (
    .clk(clk),
    .rst_n(rst_n),
    .wr_en(wr_sel[5]),
    .wr_data(reg_wdata),
    .q(r_n1)
  );
  pcfg_byte_reg #(.RST_VAL(`PCFG_RST_NUM0), .MASK(`PCFG_MSK_FULL)) u_n0 (
    .clk(clk),
    .rst_n(rst_n),
    .wr_en(wr_sel[6]),
    .wr_data(reg_wdata),
    .q(r_n0)
  );
  pcfg_byte_reg #(.RST_VAL(`PCFG_RST_DEN2), .MASK(`PCFG_MSK_TOP6)) u_d2 (
    .clk(clk),
    .rst_n(rst_n),
    .wr_en(wr_sel[7]),
    .wr_data(reg_wdata),
    .q(r_d2)
  );
  pcfg_byte_reg #(.RST_VAL(`PCFG_RST_DEN1), .MASK(`PCFG_MSK_FULL)) u_d1 (
    .clk(clk),
    .rst_n(rst_n),
    .wr_en(wr_sel[8]),
    .wr_data(reg_wdata),
    .q(r_d1)
  );
  pcfg_byte_reg #(.RST_VAL(`PCFG_RST_DEN0), .MASK(`PCFG_MSK_FULL)) u_d0 (
    .clk(clk),
    .rst_n(rst_n),
    .wr_en(wr_sel[9]),
    .wr_data(reg_wdata),
    .q(r_d0)
  );
  pcfg_byte_reg #(.RST_VAL(`PCFG_RST_MOD), .MASK(`PCFG_MSK_MOD)) u_mod (
    .clk(clk),
    .rst_n(rst_n),
    .wr_en(wr_sel[10]),
    .wr_data(reg_wdata),
    .q(r_mod)
  );
  pcfg_byte_reg #(.RST_VAL(`PCFG_RST_LOOP), .MASK(`PCFG_MSK_LOOP)) u_loop (
    .clk(clk),
    .rst_n(rst_n),
    .wr_en(wr_sel[11]),
    .wr_data(reg_wdata),
    .q(r_loop)
  );

  // ====================================================
  // field assembly toward the analog loop
  assign out_div_low = r_outdiv;
  assign ref_divide_select = r_ref[`PCFG_BIT_REFDIV];
  assign feedback_integer_value = {r_nhi[`PCFG_NINT_HI_MSB:`PCFG_FIELD_LSB], r_nlo};
  assign frac_numerator_value = {r_n2[`PCFG_FRAC_TOP_MSB:`PCFG_FIELD_LSB], r_n1, r_n0};
  assign frac_denominator_value = {r_d2[`PCFG_FRAC_TOP_MSB:`PCFG_FIELD_LSB], r_d1, r_d0};
  assign dither_select = r_mod[`PCFG_DITHER_HI:`PCFG_DITHER_LO];
  assign modulator_order = r_mod[`PCFG_ORDER_HI:`PCFG_ORDER_LO];
  assign doubler_enable = r_loop[`PCFG_BIT_DOUBLER];
  assign charge_pump_current_code = r_loop[`PCFG_CP_HI:`PCFG_CP_LO];

  // ====================================================
  // mode flags, registered so no decode glitch reaches the loop
  wire [7:0] mod_d;
  wire [7:0] loop_d;
  wire frac_mode_d;
  wire dither_active_d;
  wire reserved_code_d;
  reg frac_mode_q;
  reg dither_active_q;
  reg reserved_code_q;

  // bytes as they stand after this edge, so flags move with the fields
  assign mod_d = wr_sel[10] ? (reg_wdata & `PCFG_MSK_MOD) : r_mod;
  assign loop_d = wr_sel[11] ? (reg_wdata & `PCFG_MSK_LOOP) : r_loop;
  assign frac_mode_d = pcfg_frac(mod_d);
  assign dither_active_d = pcfg_dith(mod_d);
  assign reserved_code_d = pcfg_resv(mod_d, loop_d);

  // flag registers, reset from the reset bytes
  always @(posedge clk)
  begin
    if (!rst_n)
    begin
      frac_mode_q <= pcfg_frac(`PCFG_RST_MOD);
      dither_active_q <= pcfg_dith(`PCFG_RST_MOD);
      reserved_code_q <= pcfg_resv(`PCFG_RST_MOD, `PCFG_RST_LOOP);
    end
    else
    begin
      frac_mode_q <= frac_mode_d;
      dither_active_q <= dither_active_d;
      reserved_code_q <= reserved_code_d;
    end
  end

  // flag outputs
  assign frac_mode = frac_mode_q;
  assign dither_active = dither_active_q;
  assign config_reserved_code = reserved_code_q;

  // ====================================================
  // registered read back, zero for unmapped offsets
  always @(posedge clk)
  begin
    if (!rst_n)
      reg_rdata <= `PCFG_RDATA_ZERO;
    else
    begin
      case (reg_addr)
        `PCFG_OFS_OUTDIV_LO: reg_rdata <= r_outdiv;
        `PCFG_OFS_REFDIV: reg_rdata <= r_ref;
        `PCFG_OFS_NINT_HI: reg_rdata <= r_nhi;
        `PCFG_OFS_NINT_LO: reg_rdata <= r_nlo;
        `PCFG_OFS_NUM2: reg_rdata <= r_n2;
        `PCFG_OFS_NUM1: reg_rdata <= r_n1;
        `PCFG_OFS_NUM0: reg_rdata <= r_n0;
        `PCFG_OFS_DEN2: reg_rdata <= r_d2;
        `PCFG_OFS_DEN1: reg_rdata <= r_d1;
        `PCFG_OFS_DEN0: reg_rdata <= r_d0;
        `PCFG_OFS_MOD: reg_rdata <= r_mod;
        `PCFG_OFS_LOOP: reg_rdata <= r_loop;
        default: reg_rdata <= `PCFG_RDATA_ZERO;
      endcase
    end
  end
endmodule // pcfg_regs
`default_nettype wire

// File: tb/pcfg_regs_checker.sv
// assertion checker for the synthesizer configuration bank
`default_nettype none
module pcfg_regs_checker (
  input wire logic clk, // system clock
  input wire logic rst_n, // synchronous reset, active low
  input wire logic reg_wr, // write strobe
  input wire logic reg_hit, // offset in bank
  input wire logic ref_divide_select, // reference divide select
  input wire logic doubler_enable, // doubler on
  input wire logic frac_mode, // third order flag
  input wire logic dither_active, // dither in use
  input wire logic config_reserved_code, // reserved code flag
  input wire logic [6:0] reg_addr, // offset
  input wire logic [7:0] reg_wdata, // write data
  input wire logic [7:0] reg_rdata, // read data
  input wire logic [7:0] out_div_low, // output divider low byte
  input wire logic [11:0] feedback_integer_value, // n divider
  input wire logic [21:0] frac_numerator_value, // numerator
  input wire logic [21:0] frac_denominator_value, // denominator
  input wire logic [1:0] dither_select, // dither mode
  input wire logic [1:0] modulator_order, // modulator order
  input wire logic [3:0] charge_pump_current_code // pump code
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  // ==========
  // write strobe to one offset
  sequence s_wr(a);
    reg_wr && reg_addr == a;
  endsequence
  // write followed by a cycle that keeps the same offset
  sequence s_wr_hold(a);
    s_wr(a) ##1 reg_addr == a;
  endsequence
  a_outdiv_store: assert property (s_wr(7'h17) |=> out_div_low == $past(reg_wdata)) else $error("outdiv");
  a_refdiv_store: assert property (s_wr(7'h18) |=> ref_divide_select == $past(reg_wdata[0]))
    else $error("refdiv");
  a_nint_high: assert property (s_wr(7'h19) |=> feedback_integer_value[11:8] == $past(reg_wdata[3:0]))
    else $error("nint");
  a_num_low: assert property (s_wr(7'h1D) |=> frac_numerator_value[7:0] == $past(reg_wdata)) else $error("num");
  a_den_high: assert property (s_wr(7'h1E) |=> frac_denominator_value[21:16] == $past(reg_wdata[5:0]))
    else $error("den");
  a_mod_fields: assert property (s_wr(7'h21) |=>
    {dither_select, modulator_order} == $past(reg_wdata[3:0])) else $error("mod");
  a_loop_fields: assert property (s_wr(7'h22) |=>
    {doubler_enable, charge_pump_current_code} == {$past(reg_wdata[5]), $past(reg_wdata[3:0])})
    else $error("loop");
  a_unmapped_zero: assert property (!reg_hit |=> reg_rdata == 8'h00) else $error("unmapped");
  a_mod_readback: assert property (s_wr_hold(7'h21) |=> reg_rdata == {4'h0, $past(reg_wdata[3:0], 2)})
    else $error("readback");
  a_reset_fields: assert property ($rose(rst_n) |->
    out_div_low == 8'h4E && ref_divide_select && doubler_enable && feedback_integer_value == 12'h0DC &&
    {dither_select, modulator_order, charge_pump_current_code} == 8'h34 &&
    frac_numerator_value == 22'h1CB3E3 && frac_denominator_value == 22'h3FFFFF) else $error("reset");
  a_flag_decode: assert property (frac_mode == (modulator_order == 2'h3) &&
    dither_active == (frac_mode && dither_select == 2'h0) &&
    config_reserved_code == (^dither_select || ^modulator_order || !(charge_pump_current_code inside {4'h4, 4'h8})))
    else $error("flags");
endmodule // pcfg_regs_checker
bind pcfg_regs pcfg_regs_checker i_pcfg_regs_checker (.clk, .rst_n, .reg_wr, .reg_hit, .ref_divide_select,
  .doubler_enable, .frac_mode, .dither_active, .config_reserved_code, .reg_addr, .reg_wdata, .reg_rdata,
  .out_div_low, .feedback_integer_value, .frac_numerator_value, .frac_denominator_value, .dither_select,
  .modulator_order, .charge_pump_current_code);
`default_nettype wire

// File: tb/pcfg_regs_tb.sv
// self-checking testbench of the synthesizer configuration bank
`default_nettype none
module pcfg_regs_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 0, rst_n = 0, reg_wr = 0;
  logic [6:0] reg_addr = 7'h00;
  logic [7:0] reg_wdata = 8'h00;
  wire [7:0] reg_rdata, out_div_low;
  wire reg_hit, ref_divide_select, doubler_enable, frac_mode, dither_active, config_reserved_code;
  wire [11:0] feedback_integer_value;
  wire [21:0] frac_numerator_value, frac_denominator_value;
  wire [1:0] dither_select, modulator_order;
  wire [3:0] charge_pump_current_code;
  int n_mismatch = 0, n_compared = 0, cyc = 0;
  logic [7:0] rst_tab [12] = '{8'h4E, 8'h01, 8'h00, 8'hDC, 8'h1C, 8'hB3, 8'hE3, 8'h3F, 8'hFF, 8'hFF, 8'h03, 8'h24};
  logic [7:0] msk_tab [12] = '{8'hFF, 8'h01, 8'h0F, 8'hFF, 8'h3F, 8'hFF, 8'hFF, 8'h3F, 8'hFF, 8'hFF, 8'h0F, 8'h2F};
  pcfg_regs i_pcfg_regs (.clk, .rst_n, .reg_wr, .reg_addr, .reg_wdata, .reg_rdata, .reg_hit, .out_div_low,
    .ref_divide_select, .feedback_integer_value, .frac_numerator_value, .frac_denominator_value, .dither_select,
    .modulator_order, .doubler_enable, .charge_pump_current_code, .frac_mode, .dither_active, .config_reserved_code);
  // ==========
  // clock and cycle ceiling
  always #10 clk = ~clk;
  always @(posedge clk)
  begin
    cyc <= cyc + 1;
    if (cyc == 4000)
    begin
      n_mismatch++;
      report_and_stop();
    end
  end
  task automatic chk(string what, logic [21:0] exp, logic [21:0] got);
    n_compared++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic wr(logic [6:0] a, logic [7:0] d);
    @(negedge clk);
    {reg_wr, reg_addr, reg_wdata} = {1'b1, a, d};
    @(negedge clk);
    reg_wr = 0;
  endtask
  task automatic rd(logic [6:0] a, logic [7:0] exp);
    @(negedge clk);
    reg_addr = a;
    @(negedge clk);
    chk("rdata", exp, reg_rdata);
  endtask
  task automatic reset_check();
    rst_n = 0;
    repeat (8) @(negedge clk);
    rst_n = 1;
    for (int i = 0; i < 12; i++) rd(7'(7'h17 + i), rst_tab[i]);
    chk("nint", 22'h0DC, feedback_integer_value);
    chk("frac", 22'h1CB3E3, frac_numerator_value);
    chk("flags", 22'h6, {frac_mode, dither_active, config_reserved_code});
  endtask
  task automatic report_and_stop();
    $display("mismatches %0d compared %0d", n_mismatch, n_compared);
    if (n_mismatch == 0 && n_compared > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  // ==========
  // main sequence
  initial
  begin
    reset_check();
    for (int i = 0; i < 12; i++) wr(7'(7'h17 + i), 8'hFF);
    for (int i = 0; i < 12; i++) rd(7'(7'h17 + i), msk_tab[i]);
    chk("den", 22'h3FFFFF, frac_denominator_value);
    wr(7'h22, 8'h24);
    for (int m = 0; m < 16; m++)
    begin
      wr(7'h21, 8'(m));
      chk("mode", 22'(m), {dither_select, modulator_order});
      chk("resv", 22'((^m[3:2]) | (^m[1:0])), config_reserved_code);
      chk("fmode", 22'(m[1:0] == 2'h3), frac_mode);
      chk("dact", 22'(m[1:0] == 2'h3 && m[3:2] == 2'h0), dither_active);
    end
    wr(7'h22, 8'h08);
    chk("loop", 22'h08, {doubler_enable, config_reserved_code, charge_pump_current_code});
    wr(7'h22, 8'h05);
    chk("cpbad", 22'h1, config_reserved_code);
    wr(7'h18, 8'hFE);
    chk("refdiv", 22'h0, ref_divide_select);
    wr(7'h1B, 8'h25);
    wr(7'h1C, 8'h6A);
    wr(7'h1D, 8'h81);
    chk("num", 22'h256A81, frac_numerator_value);
    wr(7'h1E, 8'hC1);
    chk("den", 22'h01FFFF, frac_denominator_value);
    wr(7'h19, 8'hF5);
    wr(7'h1A, 8'h3C);
    chk("nint", 22'h53C, feedback_integer_value);
    wr(7'h17, 8'h05);
    wr(7'h23, 8'h00);
    wr(7'h16, 8'h00);
    rd(7'h23, 8'h00);
    chk("hit", 22'h0, reg_hit);
    chk("outdiv", 22'h05, out_div_low);
    reset_check();
    report_and_stop();
  end
endmodule // pcfg_regs_tb
`default_nettype wire
